// ===== ldo_regulator_control_defines.vh
// constants for the regulator control block: offsets, fields, resets
// assumes a 32-bit apb bus; byte address is four times the register index
// How it works
// - Control bit 7 written 1 turns the regulator off; 0 keeps it on.
// - After any reset the regulator is on with the off bit cleared.
// - Bit 4 picks the level, 0 for 2.1V and 1 for 2.6V, and resets to 1.
// - Bit 0 is a read-only dropout flag, 1 in or near dropout.
// - The interrupt request rises on dropout only while its enable is set.
// - The request has no latched pending flag and follows the live condition.
// - The dropout flag clears by itself when the condition ends.
// - Bit 6 always reads 1 and software always writes 1 there.
// - Bits 5 and 3 to 1 read as zero and ignore writes.
`ifndef LDO_REGULATOR_CONTROL_DEFINES_VH
`define LDO_REGULATOR_CONTROL_DEFINES_VH

`define CTRL_INDEX        8'hC9
`define IRQ_CFG_INDEX     8'hCA
`define CTRL_ADDR         12'h324
`define IRQ_CFG_ADDR      12'h328

`define CTRL_OFF_BIT      7
`define CTRL_RSVD_BIT     6
`define CTRL_LEVEL_BIT    4
`define CTRL_DROP_BIT     0
`define CTRL_RESET        8'h50
`define OFF_RESET         1'h0
`define LEVEL_RESET       1'h1

`define IRQ_EN_BIT        0
`define IRQ_PRIO_BIT      1
`define IRQ_EN_RESET      1'h0
`define IRQ_PRIO_RESET    1'h0

`endif

// ===== ldo_regulator_control.v
// regulator control and status block with an apb slave
// assumes i_dropout comes from the analog regulator, asynchronous
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
`include "ldo_regulator_control_defines.vh"

module ldo_regulator_control #(
    parameter ADDR_W = 12
) (
    input  wire              i_clk,
    input  wire              i_rst_n,
    input  wire              i_psel,
    input  wire              i_penable,
    input  wire              i_pwrite,
    input  wire [ADDR_W-1:0] i_paddr,
    input  wire [31:0]       i_pwdata,
    input  wire [3:0]        i_pstrb,
    input  wire              i_dropout,
    output wire [31:0]       o_prdata,
    output wire              o_pready,
    output wire              o_pslverr,
    output wire              o_regulator_off,
    output wire              o_level_high,
    output wire              o_irq,
    output wire              o_irq_priority
);

    reg        sync1_r;
    reg        sync2_r;
    reg        sync3_r;
    reg        dropout_r;
    reg        off_r;
    reg        level_r;
    reg        irq_en_r;
    reg        irq_prio_r;
    reg        irq_r;
    reg        pready_r;
    reg        pslverr_r;
    reg [31:0] prdata_r;
    reg [31:0] rdata_nxt;
    reg        hit_nxt;
    wire       access;
    wire       commit;
    wire       sel_ctrl;
    wire       sel_irq;
    wire [7:0] ctrl_view;

    assign access   = i_psel & i_penable;
    assign commit   = access & pready_r;
    assign sel_ctrl = (i_paddr == `CTRL_ADDR);
    assign sel_irq  = (i_paddr == `IRQ_CFG_ADDR);

    // three-stage input sync
    // first stage feeds only the second, so metastability stays contained
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            sync1_r <= 1'h0;
            sync2_r <= 1'h0;
            sync3_r <= 1'h0;
        end else begin
            sync1_r <= i_dropout;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // flag follows condition
    // a change counts only once stages two and three agree
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            dropout_r <= 1'h0;
        end else if (sync2_r == sync3_r) begin
            dropout_r <= sync3_r;
        end
    end

    assign ctrl_view = {off_r, 1'h1, 1'h0, level_r, 3'h0, dropout_r};

    always @* begin
        rdata_nxt = 32'h0;
        hit_nxt   = 1'h1;
        if (sel_ctrl) begin
            rdata_nxt[7:0] = ctrl_view;
        end else if (sel_irq) begin
            rdata_nxt[`IRQ_EN_BIT]   = irq_en_r;
            rdata_nxt[`IRQ_PRIO_BIT] = irq_prio_r;
        end else begin
            hit_nxt = 1'h0;
        end
    end

    // one wait state; answer is registered for clean timing
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            pready_r  <= 1'h0;
            pslverr_r <= 1'h0;
            prdata_r  <= 32'h0;
        end else if (access & ~pready_r) begin
            pready_r  <= 1'h1;
            pslverr_r <= ~hit_nxt;
            prdata_r  <= i_pwrite ? 32'h0 : rdata_nxt;
        end else begin
            pready_r  <= 1'h0;
            pslverr_r <= 1'h0;
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            off_r      <= `OFF_RESET;
            level_r    <= `LEVEL_RESET;
            irq_en_r   <= `IRQ_EN_RESET;
            irq_prio_r <= `IRQ_PRIO_RESET;
        end else if (commit & i_pwrite & i_pstrb[0]) begin
            if (sel_ctrl) begin
                off_r   <= i_pwdata[`CTRL_OFF_BIT];
                level_r <= i_pwdata[`CTRL_LEVEL_BIT];
            end else if (sel_irq) begin
                irq_en_r   <= i_pwdata[`IRQ_EN_BIT];
                irq_prio_r <= i_pwdata[`IRQ_PRIO_BIT];
            end
        end
    end

    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            irq_r <= 1'h0;
        end else begin
            irq_r <= irq_en_r & dropout_r;
        end
    end

    assign o_prdata        = prdata_r;
    assign o_pready        = pready_r;
    assign o_pslverr       = pslverr_r;
    assign o_regulator_off = off_r;
    assign o_level_high    = level_r;
    assign o_irq           = irq_r;
    assign o_irq_priority  = irq_prio_r;

endmodule

// ===== ldo_regulator_control_chk.sv
// port checker for the regulator control block
// assumes apb with one wait state, bound below
`timescale 1ns/10ps
`include "ldo_regulator_control_defines.vh"
module ldo_regulator_control_chk (
    input wire logic        i_clk, i_rst_n, i_psel, i_penable,
    input wire logic        i_pwrite, i_dropout, o_pready, o_pslverr,
    input wire logic        o_regulator_off, o_level_high, o_irq,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0]  i_pstrb
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire wr = i_psel && i_penable && o_pready && i_pwrite;
    sequence ctrl_wr;
        wr && !o_pslverr && i_paddr == `CTRL_ADDR && i_pstrb[0];
    endsequence
    reset_vals_a: assert property ($rose(i_rst_n) |->
        o_level_high && !o_regulator_off && !o_irq) else $error("reset");
    ready_once_a: assert property (o_pready |=> !o_pready)
        else $error("ready long");
    one_wait_a: assert property (i_psel && i_penable && !o_pready
        |=> o_pready) else $error("ready late");
    ready_access_a: assert property (o_pready |-> i_psel && i_penable)
        else $error("ready idle");
    err_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("err alone");
    irq_live_a: assert property (!i_dropout [*7] |=> !o_irq)
        else $error("irq held");
    off_wr_a: assert property (ctrl_wr |=>
        o_regulator_off == $past(i_pwdata[7])) else $error("off bit");
    level_wr_a: assert property (ctrl_wr |=>
        o_level_high == $past(i_pwdata[4])) else $error("level bit");
    hold_ctrl_a: assert property (!wr |=> $stable(o_regulator_off)
        && $stable(o_level_high)) else $error("ctrl moved");
endmodule
bind ldo_regulator_control ldo_regulator_control_chk i_chk (.*);

// ===== tb_ldo_regulator_control.sv
// self-checking bench for the regulator control block
// assumes one clock, apb registers, dropout as a level
`timescale 1ns/10ps
`include "ldo_regulator_control_defines.vh"
module tb_ldo_regulator_control;
    logic        i_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0;
    logic        i_pwrite = 0, i_dropout = 0, er;
    logic        o_pready, o_pslverr, o_regulator_off, o_level_high;
    logic        o_irq, o_irq_priority;
    logic [11:0] i_paddr = 12'h0;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic [3:0]  i_pstrb = 4'hF;
    integer      mismatches = 0, compares = 0;
    ldo_regulator_control i_ldo_regulator_control (.*);
    task complete_run;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, s);
        compares++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", nm, e, s);
        end
    endtask
    // bounded wait: a missing ready ends the run
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        @(posedge i_clk);
        {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'h1, w, a, d};
        @(posedge i_clk);
        i_penable <= 1'h1;
        do @(posedge i_clk); while (o_pready !== 1'h1 && ++n < 9);
        {rd, er} = {o_prdata, o_pslverr};
        {i_psel, i_penable} <= 2'h0;
        if (n == 9) begin
            mismatches++;
            complete_run;
        end
    endtask
    initial forever #5 i_clk = ~i_clk;
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'h1;
        apb(0, `CTRL_ADDR, 32'h0);
        chk("reset", 32'h50, rd);
        apb(1, `CTRL_ADDR, 32'h0);
        apb(0, `CTRL_ADDR, 32'h0);
        chk("bit6", 32'h40, rd);
        chk("level", 32'h0, o_level_high);
        apb(1, `CTRL_ADDR, 32'hFF);
        apb(0, `CTRL_ADDR, 32'h0);
        chk("ro bits", 32'hD0, rd);
        chk("off", 32'h1, o_regulator_off);
        apb(0, 12'h0, 32'h0);
        chk("unmapped", 32'h1, er);
        $display("control test done");
        apb(1, `IRQ_CFG_ADDR, 32'h3);
        i_dropout <= 1'h1;
        repeat (8) @(posedge i_clk);
        apb(0, `CTRL_ADDR, 32'h0);
        chk("flag", 32'hD1, rd);
        chk("irq", 32'h1, o_irq);
        chk("prio", 32'h1, o_irq_priority);
        apb(1, `IRQ_CFG_ADDR, 32'h0);
        repeat (2) @(posedge i_clk);
        chk("masked", 32'h0, o_irq);
        i_dropout <= 1'h0;
        repeat (8) @(posedge i_clk);
        apb(0, `CTRL_ADDR, 32'h0);
        chk("cleared", 32'hD0, rd);
        apb(1, `IRQ_CFG_ADDR, 32'h1);
        repeat (2) @(posedge i_clk);
        chk("no pending", 32'h0, o_irq);
        $display("dropout test done");
        complete_run;
    end
endmodule
